//--- logic/dds_core_consts.vh
// Constants for the synthesizer core: widths, field positions, reset values.
// Assumes inclusion by bare name from the design files.
`ifndef DDS_CORE_CONSTS_VH
`define DDS_CORE_CONSTS_VH
`define ACC_W 32
`define LUT_AW 10
`define DAC_W 10
`define CTRL_W 32
`define CR1_CLKBUF_OFF_BIT 4
`define CR1_CLR_PHASE_BIT 10
`define CR1_AUTOCLR_BIT 13
`define CR1_SDIO_IN_ONLY_BIT 9
`define CR1_OSK_EN_BIT 17
`define CR2_XOUT_EN_BIT 9
`define CR2_MULT_HI 7
`define CR2_MULT_LO 3
`define MULT_MIN 5'h04
`define MULT_MAX 5'h14
`define CR1_RESET 32'h0000_0400
`define CR1_BUF_RESET 32'h0000_0000
`define CR2_RESET 32'h0000_0000
`define WORD_RESET 32'h0000_0000
`define DAC_MID 10'h200
`define ACC_ZERO 32'h0000_0000
`define SHIFT_BITS 6'h20
`define CMD_W 8
`define ADDR_CR1 5'h00
`define ADDR_CR2 5'h01
`define ADDR_TUNE 5'h04
`endif

//--- logic/cos_rom.v
// Cosine lookup memory: phase index in, registered amplitude out.
// Assumes one clock; table built at elaboration, no file read.
`timescale 1ns/1ps
`default_nettype none
`include "dds_core_consts.vh"
module cos_rom (
   input wire clk_sys,
   input wire sys_rst,
   input wire [`LUT_AW-1:0] phase_idx,
   output reg [`DAC_W-1:0] amp_reg
);
   reg [`DAC_W-1:0] table_mem [0:(1<<`LUT_AW)-1];
   integer i;
   integer lvl;
   real ang;
   initial begin
      for (i = 0; i < (1<<`LUT_AW); i = i + 1) begin
         ang = 6.283185307 * i / (1<<`LUT_AW);
         lvl = $rtoi(511.5 + 511.0 * $cos(ang));
         // Level always fits the code width, keep the low bits only
         table_mem[i] = lvl[`DAC_W-1:0];
      end
   end
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         amp_reg <= `DAC_MID;
      end else begin
         amp_reg <= table_mem[phase_idx];
      end
   end
endmodule
`default_nettype wire

//--- logic/dds_core_clock_select.v
// Digital core of a direct digital synthesizer with serial control port,
// commit strobe, clock-mode selection and keying/sync/power-down pins.
// Assumes every pin input is asynchronous to clk_sys, the derived system clock.
// Operation
// - Hardware reset restores all registers
// - Abort pin resets serial port, drops transfer
// - Three-wire mode drives read data out
// - Data pin bidirectional only in two-wire
// - Serial transfers only while select low
// - Follower aligns timing to master divided clock
// - Keying direction sampled on divided clock
// - Thirty-two bit accumulator sets output frequency
// - Zero word freezes; clear bit forces zero
// - Power-up: clear active one, buffered zero
// - Accumulator phase converted through cosine table
// - Multiplier 4..20 multiplies reference
// - Other multiplier values bypass, power PLL down
// - Oscillator enable pin controls oscillator, buffer
// - Clock buffer bit stops system clock
// - Control two bit nine enables oscillator output
// - Buffer bit overrides multiplier and pin; code uses it only for sysclk_gate_reg
// - External power-down pin controls power-down
// - Commit strobe copies buffered writes at once
`timescale 1ns/1ps
`default_nettype none
`include "dds_core_consts.vh"
module dds_core_clock_select (
   input wire clk_sys,
   input wire sys_rst,
   input wire serial_port_abort,
   input wire device_select_low,
   input wire serial_shift_clock,
   input wire serial_data_in,
   output reg serial_data_out,
   output reg serial_data_oe,
   output reg serial_out_pin,
   input wire register_commit_strobe,
   input wire follower_align_input,
   output reg divided_clock_out,
   input wire keying_direction_pin,
   output reg keying_dir_reg,
   input wire ext_powerdown_pin,
   output reg powerdown_reg,
   input wire osc_enable_pin,
   output reg osc_enable_reg,
   output reg osc_buffer_out,
   output reg pll_enable_reg,
   output reg [4:0] pll_mult_reg,
   output reg sysclk_gate_reg,
   output reg [`DAC_W-1:0] dac_code_reg,
   output reg [`ACC_W-1:0] phase_reg
);
   // Two-flop synchronisers for every pin
   localparam NSYNC = 9;
   wire [NSYNC-1:0] pin_raw = {serial_port_abort, device_select_low, serial_shift_clock,
      serial_data_in, register_commit_strobe, follower_align_input,
      keying_direction_pin, ext_powerdown_pin, osc_enable_pin};
   reg [NSYNC-1:0] meta_reg;
   reg [NSYNC-1:0] sync_reg;
   genvar g;
   generate
      for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
         always @(posedge clk_sys) begin
            if (sys_rst) begin
               meta_reg[g] <= 1'b0;
               sync_reg[g] <= 1'b0;
            end else begin
               meta_reg[g] <= pin_raw[g];
               sync_reg[g] <= meta_reg[g];
            end
         end
      end
   endgenerate
   wire abort_s = sync_reg[8];
   wire sel_low_s = sync_reg[7];
   wire sclk_s = sync_reg[6];
   wire sdi_s = sync_reg[5];
   wire commit_s = sync_reg[4];
   wire align_s = sync_reg[3];
   wire key_s = sync_reg[2];
   wire pd_s = sync_reg[1];
   wire osc_s = sync_reg[0];

   reg sclk_d_reg, commit_d_reg, align_d_reg;
   wire sclk_rise = sclk_s & ~sclk_d_reg;
   wire sclk_fall = ~sclk_s & sclk_d_reg;
   wire commit_rise = commit_s & ~commit_d_reg;
   wire align_rise = align_s & ~align_d_reg;

   function in_range;
      input [4:0] m;
      begin
         in_range = (m >= `MULT_MIN) && (m <= `MULT_MAX);
      end
   endfunction

   // Active and buffered register copies
   reg [`CTRL_W-1:0] cr1_reg, cr1_buf_reg, cr2_reg, cr2_buf_reg;
   reg [`ACC_W-1:0] tune_reg, tune_buf_reg;

   // Serial engine: 8-bit command (bit7 = read, low 5 bits address), then 32 bits MSB first
   localparam ST_CMD = 2'h0;
   localparam ST_DATA = 2'h1;
   localparam ST_DONE = 2'h2;
   reg [1:0] st_reg;
   reg [5:0] cnt_reg;
   reg [`CMD_W-1:0] cmd_reg;
   reg [`CTRL_W-1:0] sh_reg;
   wire three_wire = cr1_reg[`CR1_SDIO_IN_ONLY_BIT];
   wire is_read = cmd_reg[`CMD_W-1];
   wire [4:0] addr = cmd_reg[4:0];
   wire port_idle = sel_low_s | abort_s;

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sclk_d_reg <= 1'b0;
         commit_d_reg <= 1'b0;
         align_d_reg <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         commit_d_reg <= commit_s;
         align_d_reg <= align_s;
      end
   end

   // Abort pin is synchronised; acts within three clocks, not purely asynchronous
   always @(posedge clk_sys) begin
      if (sys_rst || port_idle) begin
         st_reg <= ST_CMD;
         cnt_reg <= 6'h00;
         cmd_reg <= 8'h00;
         sh_reg <= 32'h0000_0000;
         serial_data_oe <= 1'b0;
         serial_data_out <= 1'b0;
         serial_out_pin <= 1'b0;
      end else begin
         case (st_reg)
            ST_CMD: begin
               if (sclk_rise) begin
                  cmd_reg <= {cmd_reg[`CMD_W-2:0], sdi_s};
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == 6'h07) begin
                     st_reg <= ST_DATA;
                     cnt_reg <= 6'h00;
                     case ({cmd_reg[3:0], sdi_s})
                        `ADDR_CR1: sh_reg <= cr1_buf_reg;
                        `ADDR_CR2: sh_reg <= cr2_buf_reg;
                        `ADDR_TUNE: sh_reg <= tune_buf_reg;
                        default: sh_reg <= 32'h0000_0000;
                     endcase
                  end
               end
            end
            ST_DATA: begin
               if (is_read && sclk_fall) begin
                  serial_out_pin <= sh_reg[`CTRL_W-1] & three_wire;
                  serial_data_out <= sh_reg[`CTRL_W-1];
                  serial_data_oe <= ~three_wire;
               end
               if (sclk_rise) begin
                  sh_reg <= {sh_reg[`CTRL_W-2:0], sdi_s};
                  cnt_reg <= cnt_reg + 6'h01;
                  if (cnt_reg == `SHIFT_BITS - 6'h01) begin
                     st_reg <= ST_DONE;
                  end
               end
            end
            ST_DONE: begin
               serial_data_oe <= 1'b0;
            end
            default: st_reg <= ST_CMD;
         endcase
      end
   end

   wire write_done = (st_reg == ST_DATA) && sclk_rise && !is_read
      && (cnt_reg == `SHIFT_BITS - 6'h01) && !port_idle;
   wire [`CTRL_W-1:0] wr_word = {sh_reg[`CTRL_W-2:0], sdi_s};

   // Buffered writes, then commit copies all at once
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         cr1_buf_reg <= `CR1_BUF_RESET;
         cr2_buf_reg <= `CR2_RESET;
         tune_buf_reg <= `WORD_RESET;
         cr1_reg <= `CR1_RESET;
         cr2_reg <= `CR2_RESET;
         tune_reg <= `WORD_RESET;
      end else begin
         if (write_done) begin
            case (addr)
               `ADDR_CR1: cr1_buf_reg <= wr_word;
               `ADDR_CR2: cr2_buf_reg <= wr_word;
               `ADDR_TUNE: tune_buf_reg <= wr_word;
               default: cr1_buf_reg <= cr1_buf_reg;
            endcase
         end
         if (commit_rise) begin
            cr1_reg <= cr1_buf_reg;
            cr2_reg <= cr2_buf_reg;
            tune_reg <= tune_buf_reg;
         end
      end
   end

   // Phase accumulator; clear holds output at zero, zero word only freezes
   reg [`ACC_W-1:0] acc_reg;
   wire clr_phase = cr1_reg[`CR1_CLR_PHASE_BIT]
      | (cr1_reg[`CR1_AUTOCLR_BIT] & commit_rise);
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         acc_reg <= `ACC_ZERO;
         phase_reg <= `ACC_ZERO;
      end else if (clr_phase) begin
         acc_reg <= `ACC_ZERO;
         phase_reg <= `ACC_ZERO;
      end else if (align_rise) begin
         acc_reg <= acc_reg;
         phase_reg <= acc_reg;
      end else begin
         acc_reg <= acc_reg + tune_reg;
         phase_reg <= acc_reg;
      end
   end

   wire [`DAC_W-1:0] amp;
   cos_rom u_cos (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .phase_idx(phase_reg[`ACC_W-1:`ACC_W-`LUT_AW]),
      .amp_reg(amp)
   );

   // Divided clock: one quarter of system rate, realigned by follower input
   reg [1:0] div_reg;
   wire [4:0] mult = cr2_reg[`CR2_MULT_HI:`CR2_MULT_LO];
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         div_reg <= 2'h0;
         divided_clock_out <= 1'b0;
         keying_dir_reg <= 1'b0;
         powerdown_reg <= 1'b0;
         osc_enable_reg <= 1'b0;
         osc_buffer_out <= 1'b0;
         pll_enable_reg <= 1'b0;
         pll_mult_reg <= 5'h00;
         sysclk_gate_reg <= 1'b0;
         dac_code_reg <= `DAC_MID;
      end else begin
         div_reg <= align_rise ? 2'h0 : div_reg + 2'h1;
         divided_clock_out <= div_reg[1];
         if (div_reg == 2'h1 && cr1_reg[`CR1_OSK_EN_BIT]) begin
            keying_dir_reg <= key_s;
         end else if (!cr1_reg[`CR1_OSK_EN_BIT]) begin
            keying_dir_reg <= 1'b0;
         end
         powerdown_reg <= pd_s;
         osc_enable_reg <= osc_s;
         osc_buffer_out <= osc_s & cr2_reg[`CR2_XOUT_EN_BIT];
         pll_enable_reg <= in_range(mult);
         pll_mult_reg <= in_range(mult) ? mult : 5'h01;
         sysclk_gate_reg <= ~cr1_reg[`CR1_CLKBUF_OFF_BIT];
         dac_code_reg <= pd_s ? `DAC_MID : amp;
      end
   end
endmodule
`default_nettype wire

//--- tb/dds_props.sv
// Checker for the synthesizer core's pin-level behaviour.
// Assumes a bind to the core; the bench keeps follower align low.
`timescale 1ns/1ps
`default_nettype none
module dds_props (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic register_commit_strobe,
   input wire logic ext_powerdown_pin,
   input wire logic osc_enable_pin,
   input wire logic device_select_low,
   input wire logic serial_data_oe,
   input wire logic osc_buffer_out,
   input wire logic pll_enable_reg,
   input wire logic [4:0] pll_mult_reg,
   input wire logic powerdown_reg,
   input wire logic [9:0] dac_code_reg,
   input wire logic [31:0] phase_reg,
   input wire logic divided_clock_out
);
   logic seen_commit_reg;
   always @(posedge clk_sys) begin
      seen_commit_reg <= !sys_rst && (seen_commit_reg || register_commit_strobe);
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence div_rise; $rose(divided_clock_out); endsequence
   sequence pd_held; ext_powerdown_pin[*6]; endsequence
   sequence bypassed; seen_commit_reg && !pll_enable_reg; endsequence
   reset_values_a: assert property (disable iff (1'b0) sys_rst |=>
      phase_reg == 32'h0 && dac_code_reg == 10'h200) else $error("bad reset state");
   powerup_clear_a: assert property (!seen_commit_reg |-> phase_reg == 32'h0)
      else $error("phase moved before commit");
   pll_range_a: assert property (pll_enable_reg |-> pll_mult_reg inside {[5'h04:5'h14]})
      else $error("pll on out of range");
   pll_bypass_a: assert property (bypassed |-> pll_mult_reg == 5'h01)
      else $error("bypass multiplier wrong");
   osc_off_a: assert property ((!osc_enable_pin)[*4] |-> !osc_buffer_out)
      else $error("osc buffer on with pin low");
   powerdown_held_a: assert property (pd_held |-> powerdown_reg && dac_code_reg == 10'h200)
      else $error("power-down not applied");
   select_idle_a: assert property (device_select_low[*4] |-> !serial_data_oe)
      else $error("data pin driven while deselected");
   div_ratio_a: assert property (div_rise |-> ##4 $rose(divided_clock_out))
      else $error("divided clock period wrong");
endmodule
`default_nettype wire

//--- tb/host_model.sv
// Host model on the serial control port, MSB first, 8-bit command.
// Assumes clk_sys from the bench; serial half period is 6 clocks.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clk_sys,
   input wire logic serial_data_out,
   input wire logic serial_data_oe,
   input wire logic serial_out_pin,
   output logic device_select_low,
   output logic serial_shift_clock,
   output wire logic serial_data_in,
   output logic serial_port_abort
);
   logic drv = 1'b0;
   initial device_select_low = 1'b1;
   initial serial_shift_clock = 1'b0;
   initial serial_port_abort = 1'b0;
   // Shared line: the core wins while it drives
   assign serial_data_in = serial_data_oe ? serial_data_out : drv;
   task automatic half();
      repeat (6) @(posedge clk_sys);
      #5;
   endtask
   // Released line toggles so a stale value never reads as data
   task automatic xfer(input logic [39:0] v, input int n, output logic [31:0] got);
      device_select_low = 1'b0;
      for (int i = 0; i < n; i++) begin
         drv = (i < 8 || !v[39]) ? v[39-i] : ~drv;
         half();
         got = {got[30:0], serial_data_oe ? serial_data_out : serial_out_pin};
         serial_shift_clock = 1'b1;
         half();
         serial_shift_clock = 1'b0;
      end
      half();
      drv = ~drv;
      // Deselect must outlast the core's pin synchroniser before the next frame
      if (n == 40) begin
         device_select_low = 1'b1;
         half();
      end
   endtask
   // Abort keeps select low, so only the abort pin can restart the frame
   task automatic stop(input logic use_abort);
      serial_port_abort = use_abort;
      device_select_low = !use_abort;
      half();
      serial_port_abort = 1'b0;
      half();
   endtask
endmodule
`default_nettype wire

//--- tb/dds_core_clock_select_tb.sv
// Self-checking bench for the synthesizer core driven by a host model.
// Assumes the core, host model and checker compile beside it.
`timescale 1ns/1ps
`default_nettype none
`include "dds_core_consts.vh"
module dds_core_clock_select_tb;
   logic clk_sys = 1'b0, sys_rst = 1'b1, register_commit_strobe = 1'b0;
   logic follower_align_input = 1'b0, keying_direction_pin = 1'b0;
   logic ext_powerdown_pin = 1'b0, osc_enable_pin = 1'b1, ok;
   wire device_select_low, serial_shift_clock, serial_data_in, serial_port_abort;
   wire serial_data_out, serial_data_oe, serial_out_pin, divided_clock_out, keying_dir_reg;
   wire powerdown_reg, osc_enable_reg, osc_buffer_out, pll_enable_reg, sysclk_gate_reg;
   wire [4:0] pll_mult_reg;
   wire [9:0] dac_code_reg;
   wire [31:0] phase_reg;
   logic [31:0] w, cr2, rd_val, phase_prev, exp_q[$];
   logic [4:0] mt[5] = '{5'h03, 5'h04, 5'h14, 5'h15, 5'h0c};
   string nm_q[$], mon_nm;
   int n_mismatch = 0, total_checks = 0;
   event chk_ev;
   dds_core_clock_select i_dut (.clk_sys, .sys_rst, .serial_port_abort, .device_select_low,
      .serial_shift_clock, .serial_data_in, .serial_data_out, .serial_data_oe, .serial_out_pin,
      .register_commit_strobe, .follower_align_input, .divided_clock_out, .keying_direction_pin,
      .keying_dir_reg, .ext_powerdown_pin, .powerdown_reg, .osc_enable_pin, .osc_enable_reg,
      .osc_buffer_out, .pll_enable_reg, .pll_mult_reg, .sysclk_gate_reg, .dac_code_reg, .phase_reg);
   host_model i_host (.clk_sys, .serial_data_out, .serial_data_oe, .serial_out_pin,
      .device_select_low, .serial_shift_clock, .serial_data_in, .serial_port_abort);
   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) phase_prev <= phase_reg;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #5;
   endtask
   task automatic note(input string nm, input logic [31:0] e);
      nm_q.push_back(nm);
      exp_q.push_back(e);
      -> chk_ev;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] g;
      i_host.xfer({3'h0, a, d}, 40, g);
   endtask
   task automatic commit();
      register_commit_strobe = 1'b1;
      tick(2);
      register_commit_strobe = 1'b0;
      tick(10);
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   function automatic logic [31:0] pick(input string nm);
      case (nm)
         "phase": return phase_reg;
         "step": return phase_reg - phase_prev;
         "pll_en": return {31'h0, pll_enable_reg};
         "mult": return {27'h0, pll_mult_reg};
         "oscbuf": return {31'h0, osc_buffer_out};
         "osc": return {31'h0, osc_enable_reg};
         "gate": return {31'h0, sysclk_gate_reg};
         "keying": return {31'h0, keying_dir_reg};
         "pd": return {31'h0, powerdown_reg};
         "dac": return {22'h0, dac_code_reg};
         default: return rd_val;
      endcase
   endfunction
   always @(chk_ev) begin
      while (exp_q.size() > 0) begin
         mon_nm = nm_q.pop_front();
         cmp(mon_nm, exp_q.pop_front(), pick(mon_nm));
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #8_000_000;
      n_mismatch++;
      wrap_up();
   end
   initial begin
      void'($urandom(47));
      tick(3);
      sys_rst = 1'b0;
      tick(20);
      note("phase", 32'h0);
      w = $urandom | 32'h1;
      wr(`ADDR_TUNE, w);
      wr(`ADDR_CR1, 32'h0);
      note("phase", 32'h0);
      commit();
      note("step", w);
      $display("test accumulate done");
      i_host.xfer({8'h04, ~w}, 20, rd_val);
      i_host.stop(1'b1);
      wr(`ADDR_TUNE, 32'h0);
      commit();
      note("step", 32'h0);
      i_host.xfer({8'h04, w}, 30, rd_val);
      i_host.stop(1'b0);
      wr(`ADDR_TUNE, 32'h0);
      commit();
      note("step", 32'h0);
      wr(`ADDR_CR1, 32'h400);
      commit();
      note("phase", 32'h0);
      $display("test serial abort and clear done");
      mt[4] = 5'h04 + 5'($urandom % 17);
      foreach (mt[k]) begin
         cr2 = {22'h0, 1'b1, 1'b0, mt[k], 3'h0};
         ok = mt[k] inside {[5'h04:5'h14]};
         wr(`ADDR_CR2, cr2);
         commit();
         tick(10_000);
         note("pll_en", {31'h0, ok});
         note("mult", ok ? {27'h0, mt[k]} : 32'h1);
         note("oscbuf", 32'h1);
      end
      $display("test multiplier done");
      keying_direction_pin = 1'b1;
      wr(`ADDR_CR1, 32'h2_0210);
      commit();
      note("gate", 32'h0);
      note("keying", 32'h1);
      i_host.xfer({8'h81, 32'h0}, 40, rd_val);
      note("read", cr2);
      wr(`ADDR_CR1, 32'h2_0000);
      commit();
      note("gate", 32'h1);
      i_host.xfer({8'h81, 32'h0}, 40, rd_val);
      note("read", cr2);
      osc_enable_pin = 1'b0;
      ext_powerdown_pin = 1'b1;
      tick(10);
      note("oscbuf", 32'h0);
      note("pd", 32'h1);
      note("dac", 32'h200);
      note("osc", 32'h0);
      $display("test pins and readback done");
      tick(1);
      wrap_up();
   end
endmodule
bind dds_core_clock_select dds_props i_props (.clk_sys, .sys_rst, .register_commit_strobe,
   .ext_powerdown_pin, .osc_enable_pin, .device_select_low, .serial_data_oe, .osc_buffer_out,
   .pll_enable_reg, .pll_mult_reg, .powerdown_reg, .dac_code_reg, .phase_reg, .divided_clock_out);
`default_nettype wire
